// [hdl/mgmt_bits_pkg.sv]
// constants and carriers for the management register bit bank
// shared by the bank and whatever frames its register accesses
package mgmt_bits_pkg;

    localparam int          STRAP_WIDTH   = 5;
    localparam int          PEAK_WIDTH    = 3;
    localparam logic        LATCH_HIGH_RESET = 1'h0;
    localparam logic        LATCH_LOW_RESET  = 1'h1;
    localparam logic [2:0]  PEAK_RESET    = 3'h0;
    localparam logic        TRIGGER_RESET = 1'h0;
    localparam logic        OVERRIDE_RESET = 1'h0;
    localparam logic [7:0]  PLAIN_RESET   = 8'h00;
    localparam logic [7:0]  WZERO_RESET   = 8'hFF;
    localparam logic [7:0]  GATED_RESET   = 8'h00;
    localparam logic [7:0]  READ_ONLY_RESET = 8'h00;

    // one management access, already decoded to the bit groups
    typedef struct packed {
        logic       writeStb;
        logic       readStb;
        logic       selStatus;
        logic       selPeak;
        logic       selTrigger;
        logic       selOverride;
        logic       selPlain;
        logic       selWzero;
        logic       selGated;
        logic       selReadOnly;
        logic [7:0] wdata;
    } mgmt_access_t;

    // live levels from the rest of the device
    typedef struct packed {
        logic       eventHigh;
        logic       eventLowN;
        logic [2:0] machineState;
        logic       triggerDone;
    } monitor_t;

    typedef enum logic [1:0] {
        TRIG_IDLE,
        TRIG_BUSY
    } trig_state_t;

endpackage

// [hdl/mgmt_bit_bank.sv]
// management register bit bank: latching, peak-hold, self-clearing,
// gated and write-zero-only bits
// assumes accesses and monitored signals are synchronous to sys_clk
`timescale 1ns/100ps

// Contract
// - any reset loads every bit's default
// - defaults are zero, one, or none
// - strap bits sample their pins just after reset ends
// - latch-high bit holds until read or reset
// - after read, latch-high reloads live level
// - latch-low bit holds zero until read/reset
// - after read, latch-low reloads live level
// - peak group updates only on larger value
// - peak held until read or reset
// - after read, peak reloads present state
// - trigger bit resets zero; write one starts
// - trigger bit clears itself on completion
// - writes to read-only bits ignored
// - gated bits writable once after override set
// - write-zero-only bits accept only zeros
module mgmt_bit_bank
    import mgmt_bits_pkg::*;
#(
    parameter int STRAPS = STRAP_WIDTH
) (
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic               softReset,
    input  wire logic [STRAPS-1:0]  strapPins,
    input  wire mgmt_access_t       access,
    input  wire monitor_t           monitor,
    output logic                    latchHigh,
    output logic                    latchLow,
    output logic [PEAK_WIDTH-1:0]   peakHold,
    output logic                    triggerBit,
    output logic                    triggerStart,
    output logic                    overrideBit,
    output logic [7:0]              plainBits,
    output logic [7:0]              wzeroBits,
    output logic [7:0]              gatedBits,
    output logic [STRAPS-1:0]       strapBits,
    output logic [7:0]              readOnlyBits
);

    logic                  resetMeta;
    logic                  resetSync;
    logic                  strapPending;
    logic                  next_latchHigh;
    logic                  next_latchLow;
    logic [PEAK_WIDTH-1:0] next_peakHold;
    logic                  next_triggerBit;
    logic                  next_triggerStart;
    logic                  next_overrideBit;
    logic [7:0]            next_plainBits;
    logic [7:0]            next_wzeroBits;
    logic [7:0]            next_gatedBits;
    logic [STRAPS-1:0]     next_strapBits;
    logic                  next_strapPending;
    trig_state_t           trigState;
    trig_state_t           next_trigState;
    logic                  bankReset;

    // two-stage release of the asynchronous reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            resetMeta <= 1'h0;
            resetSync <= 1'h0;
        end else begin
            resetMeta <= 1'h1;
            resetSync <= resetMeta;
        end
    end

    // software reset goes through the same default load
    assign bankReset = !resetSync || softReset;

    always_comb begin
        next_latchHigh    = latchHigh;
        next_latchLow     = latchLow;
        next_peakHold     = peakHold;
        next_triggerBit   = triggerBit;
        next_triggerStart = 1'h0;
        next_overrideBit  = overrideBit;
        next_plainBits    = plainBits;
        next_wzeroBits    = wzeroBits;
        next_gatedBits    = gatedBits;
        next_strapBits    = strapBits;
        next_strapPending = 1'h0;
        next_trigState    = trigState;
        if (bankReset) begin
            next_latchHigh   = LATCH_HIGH_RESET;
            next_latchLow    = LATCH_LOW_RESET;
            next_peakHold    = PEAK_RESET;
            next_triggerBit  = TRIGGER_RESET;
            next_overrideBit = OVERRIDE_RESET;
            next_plainBits   = PLAIN_RESET;
            next_wzeroBits   = WZERO_RESET;
            next_gatedBits   = GATED_RESET;
            next_trigState   = TRIG_IDLE;
            next_strapPending = 1'h1;
        end else begin
            // strap pins caught on the first cycle after reset ends
            if (strapPending) begin
                next_strapBits = strapPins;
            end
            // read reloads live level; a live event still wins
            if (access.readStb && access.selStatus) begin
                next_latchHigh = monitor.eventHigh;
                next_latchLow  = monitor.eventLowN;
            end else begin
                next_latchHigh = latchHigh | monitor.eventHigh;
                next_latchLow  = latchLow & monitor.eventLowN;
            end
            if (access.readStb && access.selPeak) begin
                next_peakHold = monitor.machineState;
            end else if (monitor.machineState > peakHold) begin
                next_peakHold = monitor.machineState;
            end
            if (access.writeStb) begin
                // read-only and strap bits have no write path
                if (access.selPlain) begin
                    next_plainBits = access.wdata;
                end
                if (access.selWzero) begin
                    next_wzeroBits = wzeroBits & access.wdata;
                end
                if (access.selGated && overrideBit) begin
                    next_gatedBits = access.wdata;
                end
                // override opens exactly one following write
                if (access.selOverride) begin
                    next_overrideBit = access.wdata[0];
                end else begin
                    next_overrideBit = 1'h0;
                end
            end
            case (trigState)
                TRIG_IDLE: begin
                    if (access.writeStb && access.selTrigger && access.wdata[0]) begin
                        next_triggerBit   = 1'h1;
                        next_triggerStart = 1'h1;
                        next_trigState    = TRIG_BUSY;
                    end
                end
                TRIG_BUSY: begin
                    // further writes ignored until the function ends
                    if (monitor.triggerDone) begin
                        next_triggerBit = 1'h0;
                        next_trigState  = TRIG_IDLE;
                    end
                end
                default: begin
                    next_trigState = TRIG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            latchHigh    <= LATCH_HIGH_RESET;
            latchLow     <= LATCH_LOW_RESET;
            peakHold     <= PEAK_RESET;
            triggerBit   <= TRIGGER_RESET;
            triggerStart <= 1'h0;
            overrideBit  <= OVERRIDE_RESET;
            plainBits    <= PLAIN_RESET;
            wzeroBits    <= WZERO_RESET;
            gatedBits    <= GATED_RESET;
            strapBits    <= '0;
            strapPending <= 1'h1;
            trigState    <= TRIG_IDLE;
        end else begin
            latchHigh    <= next_latchHigh;
            latchLow     <= next_latchLow;
            peakHold     <= next_peakHold;
            triggerBit   <= next_triggerBit;
            triggerStart <= next_triggerStart;
            overrideBit  <= next_overrideBit;
            plainBits    <= next_plainBits;
            wzeroBits    <= next_wzeroBits;
            gatedBits    <= next_gatedBits;
            strapBits    <= next_strapBits;
            strapPending <= next_strapPending;
            trigState    <= next_trigState;
        end
    end

    // reserved test bits: constant, no write path at all
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            readOnlyBits <= READ_ONLY_RESET;
        end else begin
            readOnlyBits <= READ_ONLY_RESET;
        end
    end

    sequence s_quiet;
        !bankReset && !access.readStb;
    endsequence

    a_high_holds: assert property (@(posedge sys_clk) disable iff (bankReset)
        (latchHigh && !(access.readStb && access.selStatus)) |=> latchHigh)
        else $error("latch-high bit dropped without read");
    a_high_reload: assert property (@(posedge sys_clk) disable iff (bankReset)
        (access.readStb && access.selStatus) |=> latchHigh == $past(monitor.eventHigh))
        else $error("latch-high bit not reloaded after read");
    a_low_holds: assert property (@(posedge sys_clk) disable iff (bankReset)
        (!latchLow && !(access.readStb && access.selStatus)) |=> !latchLow)
        else $error("latch-low bit rose without read");
    a_low_reload: assert property (@(posedge sys_clk) disable iff (bankReset)
        (access.readStb && access.selStatus) |=> latchLow == $past(monitor.eventLowN))
        else $error("latch-low bit not reloaded after read");
    a_peak_monotone: assert property (@(posedge sys_clk) disable iff (bankReset)
        (s_quiet ##0 !access.selPeak) |=> peakHold >= $past(peakHold))
        else $error("peak value decreased without read");
    a_peak_reload: assert property (@(posedge sys_clk) disable iff (bankReset)
        (access.readStb && access.selPeak) |=> peakHold == $past(monitor.machineState))
        else $error("peak not reloaded after read");
    a_trigger_start: assert property (@(posedge sys_clk) disable iff (bankReset)
        (trigState == TRIG_IDLE && access.writeStb && access.selTrigger && access.wdata[0])
        |=> triggerBit && triggerStart)
        else $error("trigger write did not start function");
    a_trigger_clear: assert property (@(posedge sys_clk) disable iff (bankReset)
        (trigState == TRIG_BUSY && monitor.triggerDone) |=> !triggerBit)
        else $error("trigger bit not cleared on completion");
    a_gated_locked: assert property (@(posedge sys_clk) disable iff (bankReset)
        !overrideBit |=> gatedBits == $past(gatedBits))
        else $error("gated bits changed without override");
    a_override_once: assert property (@(posedge sys_clk) disable iff (bankReset)
        (access.writeStb && !access.selOverride) |=> !overrideBit)
        else $error("override survived a register write");
    a_wzero_only: assert property (@(posedge sys_clk) disable iff (bankReset)
        1'h1 |=> (wzeroBits & ~$past(wzeroBits)) == 8'h00)
        else $error("write-zero-only bit was set");
    a_reset_default: assert property (@(posedge sys_clk)
        (resetSync && softReset) |=> (!latchHigh && latchLow && peakHold == PEAK_RESET && !triggerBit))
        else $error("defaults not loaded on reset");

endmodule

// [verif/mgmt_station_model.sv]
// station management model: issues one decoded access per call
// assumes calls start on the bench clock, one at a time
`timescale 1ns/100ps
module mgmt_station_model
    import mgmt_bits_pkg::*;
(
    input  wire logic   sys_clk,
    output mgmt_access_t access
);
    initial begin
        access = '0;
    end
    // group 0 status, 1 peak, 2 trigger, 3 override, 4 plain, 5 wzero, 6 gated, 7 read-only
    task automatic doAccess(input logic isWrite, input logic [2:0] group, input logic [7:0] data);
        @(posedge sys_clk);
        #1;
        // exactly one group select per access; group 7 writes reach the read-only bits, which ignore them
        access = {isWrite, !isWrite, 8'h80 >> group, data};
        @(posedge sys_clk);
        #1;
        // released data must not keep showing the last value
        access = {10'h000, ~data};
    endtask
endmodule

// [verif/mgmt_bit_bank_bench.sv]
// self-checking bench for the management bit bank
// assumes the station model drives access; bench drives straps and monitors
`timescale 1ns/100ps
module mgmt_bit_bank_bench
    import mgmt_bits_pkg::*;
;
    logic sysClk, resetN, softReset, latchHigh, latchLow, triggerBit, triggerStart, overrideBit;
    logic [STRAP_WIDTH-1:0] strapPins, strapBits;
    logic [PEAK_WIDTH-1:0]  peakHold;
    logic [7:0]             plainBits, wzeroBits, gatedBits, readOnlyBits;
    mgmt_access_t           access;
    monitor_t               monitor;
    int                     mismatches, checked;

    mgmt_station_model i_mgmt_station_model (.sys_clk(sysClk), .access(access));
    mgmt_bit_bank i_mgmt_bit_bank (.sys_clk(sysClk), .reset_n(resetN), .softReset(softReset),
        .strapPins(strapPins), .access(access), .monitor(monitor), .latchHigh(latchHigh),
        .latchLow(latchLow), .peakHold(peakHold), .triggerBit(triggerBit), .triggerStart(triggerStart),
        .overrideBit(overrideBit), .plainBits(plainBits), .wzeroBits(wzeroBits), .gatedBits(gatedBits),
        .strapBits(strapBits), .readOnlyBits(readOnlyBits));

    initial begin
        sysClk = 1'h0;
        forever #2 sysClk = ~sysClk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sysClk);
        #1;
    endtask
    task automatic rd(input logic [2:0] g);
        i_mgmt_station_model.doAccess(1'h0, g, 8'h00);
    endtask
    task automatic wr(input logic [2:0] g, input logic [7:0] d);
        i_mgmt_station_model.doAccess(1'h1, g, d);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic checkDefaults(input logic [4:0] s);
        chk(8'(latchHigh), 8'(LATCH_HIGH_RESET));
        chk(8'(latchLow), 8'(LATCH_LOW_RESET));
        chk(8'(peakHold), 8'(PEAK_RESET));
        chk(8'(triggerBit), 8'(TRIGGER_RESET));
        chk(8'(triggerStart), 8'h00);
        chk(8'(overrideBit), 8'(OVERRIDE_RESET));
        chk(plainBits, PLAIN_RESET);
        chk(wzeroBits, WZERO_RESET);
        chk(gatedBits, GATED_RESET);
        chk(readOnlyBits, READ_ONLY_RESET);
        chk(8'(strapBits), 8'(s));
    endtask
    task automatic testLatch();
        monitor.eventHigh = 1'h1;
        monitor.eventLowN = 1'h0;
        tick(1);
        monitor.eventHigh = 1'h0;
        monitor.eventLowN = 1'h1;
        tick(3);
        chk(8'(latchHigh), 8'h01);
        chk(8'(latchLow), 8'h00);
        rd(3'h0);
        chk(8'(latchHigh), 8'h00);
        chk(8'(latchLow), 8'h01);
        // events arrive only in the read cycle itself
        fork
            rd(3'h0);
            begin
                tick(1);
                monitor.eventHigh = 1'h1;
                monitor.eventLowN = 1'h0;
                tick(1);
                monitor.eventHigh = 1'h0;
                monitor.eventLowN = 1'h1;
            end
        join
        chk(8'(latchHigh), 8'h01);
        chk(8'(latchLow), 8'h00);
        // second read in a row shows the live levels
        rd(3'h0);
        chk(8'(latchHigh), 8'h00);
        chk(8'(latchLow), 8'h01);
    endtask
    task automatic testPeak();
        monitor.machineState = 3'h6;
        tick(1);
        monitor.machineState = 3'h2;
        tick(2);
        chk(8'(peakHold), 8'h06);
        monitor.machineState = 3'h7;
        tick(1);
        monitor.machineState = 3'h3;
        tick(2);
        chk(8'(peakHold), 8'h07);
        rd(3'h1);
        chk(8'(peakHold), 8'h03);
        monitor.machineState = 3'h1;
        rd(3'h1);
        chk(8'(peakHold), 8'h01);
        monitor.machineState = 3'h0;
    endtask
    task automatic testTrigger();
        wr(3'h2, 8'h01);
        chk({7'h00, triggerBit}, 8'h01);
        chk({7'h00, triggerStart}, 8'h01);
        // a second trigger while busy must not restart the function
        wr(3'h2, 8'h01);
        chk({triggerStart, 6'h00, triggerBit}, 8'h01);
        tick(3);
        chk({triggerStart, 6'h00, triggerBit}, 8'h01);
        monitor.triggerDone = 1'h1;
        tick(1);
        monitor.triggerDone = 1'h0;
        chk(8'(triggerBit), 8'h00);
    endtask
    task automatic testWrites();
        wr(3'h7, 8'hFF);
        chk(readOnlyBits, READ_ONLY_RESET);
        wr(3'h6, 8'h5A);
        chk(gatedBits, GATED_RESET);
        wr(3'h3, 8'h01);
        chk(8'(overrideBit), 8'h01);
        wr(3'h4, 8'hA5);
        chk(8'(overrideBit), 8'h00);
        wr(3'h3, 8'h01);
        wr(3'h6, 8'h5A);
        chk(gatedBits, 8'h5A);
        wr(3'h6, 8'h3C);
        chk(gatedBits, 8'h5A);
        wr(3'h5, 8'hF0);
        chk(wzeroBits, 8'hF0);
        wr(3'h5, 8'hFF);
        chk(wzeroBits, 8'hF0);
    endtask

    initial begin
        mismatches = 0;
        checked = 0;
        resetN = 1'h0;
        softReset = 1'h0;
        strapPins = 5'h15;
        monitor = '0;
        monitor.eventLowN = 1'h1;
        tick(10);
        resetN = 1'h1;
        tick(4);
        checkDefaults(5'h15);
        testLatch();
        testPeak();
        testTrigger();
        testWrites();
        strapPins = 5'h0A;
        softReset = 1'h1;
        tick(2);
        softReset = 1'h0;
        tick(3);
        checkDefaults(5'h0A);
        stop_test();
    end
endmodule
